// ---- hw/wtc_consts.svh ----
`ifndef WTC_CONSTS_SVH
`define WTC_CONSTS_SVH
`define WTC_A_RATE 8'h00
`define WTC_A_ZOOM 8'h04
`define WTC_A_REFMODE 8'h08
`define WTC_A_TSRC 8'h0c
`define WTC_A_STATEN 8'h10
`define WTC_A_CMD 8'h14
`define WTC_A_STATUS 8'h18
`define WTC_A_CRES 8'h1c
`define WTC_A_AREA 8'h20
`define WTC_A_ZONE 8'h24
`define WTC_A_CORO 8'h28
`define WTC_A_PHAS 8'h2c
`define WTC_A_FREQ 8'h30
`define WTC_A_VOLT 8'h34
`define WTC_A_TIME 8'h38
`define WTC_A_STAT 8'h40
`define WTC_A_STEND 8'h64
`define WTC_C_REF 0
`define WTC_C_CHOOSE 1
`define WTC_C_CLR 2
`define WTC_C_SAVE 3
`define WTC_C_TRIG 4
`define WTC_C_FREF 5
`define WTC_C_FTST 6
`define WTC_CH_ON 8'h31
`define WTC_CH_OFF 8'h30
`define WTC_CRES_OFF 32'h00000002
`define WTC_CRES_NODATA 32'h00000003
`define WTC_NA_F 32'h7e94f571
`define WTC_NA_CORO 32'h0000270f
`define WTC_PTS_MIN 10'h3c0
`define WTC_PTS_MED 10'h1e0
`define WTC_PTS_MAX 10'h0f0
`define WTC_NCNT 10
`define WTC_RATE_RST 3'h0
`endif

// ---- hw/wtc_pkg.sv ----
package wtc_pkg;
	typedef enum logic [1:0] {ZOOM_MIN, ZOOM_MED, ZOOM_MAX, ZOOM_BAD} wtc_zoom_t;
	typedef enum logic [1:0] {sequence_cycle_mode, single_cycle_mode, single_sample_mode, REFMODE_BAD}
		wtc_refmode_t;
	typedef enum logic [1:0] {manual_trigger, SRC_EXT, SRC_INT, SRC_BUS} wtc_tsrc_t;
	typedef enum logic [1:0] {REF_IDLE, REF_RUN, REF_DONE} wtc_ref_t;
	typedef struct packed {
		logic func_on;
		logic [3:0] cmp_en;
		logic [4:0] pass;
		logic [31:0] area;
		logic [31:0] zone;
		logic [15:0] coro;
		logic [31:0] phas;
	} wtc_meas_t;
	typedef struct packed {
		logic [31:0] freq;
		logic cur_same;
		logic [31:0] volt;
		logic [31:0] tim;
	} wtc_cursor_t;
	typedef struct packed {
		logic rdy;
		logic err;
		logic [31:0] rdata;
		logic [2:0] rate;
		wtc_zoom_t zoom;
		logic [9:0] pts;
		wtc_refmode_t ref_mode;
		wtc_tsrc_t tsrc;
		logic [7:0] stat_ch;
		wtc_ref_t ref_st;
		logic ref_fin;
		logic [1:0] pend;
		logic send;
		logic kind;
		logic meas_go;
		logic ref_go;
		logic choose;
		logic save;
		logic [9:0][15:0] cnt;
	} wtc_state_t;
endpackage

// ---- hw/wtc_top.sv ----
`timescale 1ns/1ns
`include "wtc_consts.svh"
module wtc_top
	import wtc_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// tester status
	input wire logic testing,
	input wire logic page_meas,
	input wire logic wave_ready,
	input wire logic meas_done,
	input wire logic ref_pass_done,
	input wire wtc_meas_t meas,
	input wire wtc_cursor_t cursor,
	// control outputs
	output logic [2:0] rate_sel,
	output logic [1:0] zoom_sel,
	output logic [9:0] zoom_pts,
	output logic meas_start,
	output logic ref_start,
	output logic ref_choose,
	output logic stat_save,
	// waveform output buffer request
	output logic wave_send,
	output logic wave_kind
);
	wtc_state_t s_ff;
	wtc_state_t nxt_s;
	logic acc;
	logic wr;
	logic [31:0] cmd;
	logic [7:0] soff;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		hit = (a == o);
	endfunction

	function automatic logic in_stat(input logic [7:0] a);
		in_stat = (a >= `WTC_A_STAT) && (a <= `WTC_A_STEND) && (a[1:0] == 2'h0);
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		mapped = (a[1:0] == 2'h0) && ((a <= `WTC_A_TIME) || in_stat(a));
	endfunction

	function automatic logic [9:0] pts(input wtc_zoom_t z);
		unique case (z)
			ZOOM_MIN: pts = `WTC_PTS_MIN;
			ZOOM_MED: pts = `WTC_PTS_MED;
			default: pts = `WTC_PTS_MAX;
		endcase
	endfunction

	assign acc = psel & penable & s_ff.rdy;
	assign wr = acc & pwrite & mapped(paddr);
	assign cmd = (wr && hit(paddr, `WTC_A_CMD)) ? pwdata : 32'h0;
	assign soff = paddr - `WTC_A_STAT;

	always_comb begin
		nxt_s = s_ff;
		nxt_s.meas_go = 1'b0;
		nxt_s.ref_go = 1'b0;
		nxt_s.choose = 1'b0;
		nxt_s.save = 1'b0;
		nxt_s.send = 1'b0;
		nxt_s.err = 1'b0;
		nxt_s.rdy = psel & penable & ~s_ff.rdy;
		// read data is formed one cycle ahead so it leaves a flop
		if (psel & penable & ~s_ff.rdy) begin
			nxt_s.err = ~mapped(paddr);
			nxt_s.rdata = 32'h0;
			if (hit(paddr, `WTC_A_RATE)) begin
				nxt_s.rdata = {16'h0, 8'h01 << s_ff.rate, 5'h0, s_ff.rate};
			end else if (hit(paddr, `WTC_A_ZOOM)) begin
				nxt_s.rdata = {6'h0, pts(s_ff.zoom), 14'h0, s_ff.zoom};
			end else if (hit(paddr, `WTC_A_REFMODE)) begin
				nxt_s.rdata = {30'h0, s_ff.ref_mode};
			end else if (hit(paddr, `WTC_A_TSRC)) begin
				nxt_s.rdata = {30'h0, s_ff.tsrc};
			end else if (hit(paddr, `WTC_A_STATEN)) begin
				nxt_s.rdata = {24'h0, s_ff.stat_ch};
			end else if (hit(paddr, `WTC_A_STATUS)) begin
				nxt_s.rdata = {24'h0, wave_ready, s_ff.pend, s_ff.ref_fin, s_ff.ref_st, page_meas, testing};
			end else if (hit(paddr, `WTC_A_CRES)) begin
				if (!meas.func_on) begin
					nxt_s.rdata = `WTC_CRES_OFF;
				end else if (!wave_ready) begin
					nxt_s.rdata = `WTC_CRES_NODATA;
				end else begin
					nxt_s.rdata = {31'h0, meas.pass[0]};
				end
			end else if (hit(paddr, `WTC_A_AREA)) begin
				nxt_s.rdata = meas.cmp_en[0] ? meas.area : `WTC_NA_F;
			end else if (hit(paddr, `WTC_A_ZONE)) begin
				nxt_s.rdata = meas.cmp_en[1] ? meas.zone : `WTC_NA_F;
			end else if (hit(paddr, `WTC_A_CORO)) begin
				nxt_s.rdata = meas.cmp_en[2] ? {16'h0, meas.coro} : `WTC_NA_CORO;
			end else if (hit(paddr, `WTC_A_PHAS)) begin
				nxt_s.rdata = meas.cmp_en[3] ? meas.phas : `WTC_NA_F;
			end else if (hit(paddr, `WTC_A_FREQ)) begin
				nxt_s.rdata = cursor.cur_same ? `WTC_NA_F : cursor.freq;
			end else if (hit(paddr, `WTC_A_VOLT)) begin
				nxt_s.rdata = cursor.volt;
			end else if (hit(paddr, `WTC_A_TIME)) begin
				nxt_s.rdata = cursor.tim;
			end else if (in_stat(paddr)) begin
				nxt_s.rdata = {16'h0, s_ff.cnt[soff[5:2]]};
			end
		end
		// settings; a refused write leaves everything as it was
		if (wr && hit(paddr, `WTC_A_RATE) && !testing) begin
			nxt_s.rate = pwdata[2:0];
		end
		if (wr && hit(paddr, `WTC_A_ZOOM) && !testing && pwdata[1:0] != ZOOM_BAD) begin
			nxt_s.zoom = wtc_zoom_t'(pwdata[1:0]);
		end
		// point count kept in a flop so the output carries no decode
		nxt_s.pts = pts(nxt_s.zoom);
		if (wr && hit(paddr, `WTC_A_REFMODE) && pwdata[1:0] != REFMODE_BAD) begin
			nxt_s.ref_mode = wtc_refmode_t'(pwdata[1:0]);
		end
		if (wr && hit(paddr, `WTC_A_TSRC)) begin
			nxt_s.tsrc = wtc_tsrc_t'(pwdata[1:0]);
		end
		if (wr && hit(paddr, `WTC_A_STATEN)) begin
			if (pwdata[7:0] == `WTC_CH_ON || pwdata[7:0] == `WTC_CH_OFF) begin
				nxt_s.stat_ch = pwdata[7:0];
			end
		end
		// statistics; clear wins over a count in the same cycle
		if (meas_done && s_ff.stat_ch == `WTC_CH_ON) begin
			for (int k = 0; k < 5; k++) begin
				if (k == 0 || meas.cmp_en[k - 1]) begin
					nxt_s.cnt[2 * k] = s_ff.cnt[2 * k] + 16'h1;
					if (meas.pass[k]) begin
						nxt_s.cnt[2 * k + 1] = s_ff.cnt[2 * k + 1] + 16'h1;
					end
				end
			end
		end
		if (cmd[`WTC_C_CLR]) begin
			nxt_s.cnt = '0;
		end
		nxt_s.save = cmd[`WTC_C_SAVE];
		nxt_s.meas_go = cmd[`WTC_C_TRIG] & page_meas;
		// fetch requests wait for data; a new request is never lost
		if (cmd[`WTC_C_FREF]) begin
			nxt_s.pend[0] = 1'b1;
		end
		if (cmd[`WTC_C_FTST]) begin
			nxt_s.pend[1] = 1'b1;
		end
		// reference sampler
		unique case (s_ff.ref_st)
			REF_IDLE: begin
			end
			REF_RUN: begin
				if (ref_pass_done) begin
					nxt_s.send = 1'b1;
					nxt_s.kind = 1'b0;
					nxt_s.ref_fin = 1'b1;
					if (s_ff.ref_mode == single_cycle_mode) begin
						nxt_s.ref_st = REF_DONE;
					end else if (s_ff.ref_mode == single_sample_mode) begin
						nxt_s.ref_st = REF_IDLE;
						nxt_s.ref_fin = 1'b0;
					end
				end
			end
			REF_DONE: begin
				if (wr && hit(paddr, `WTC_A_RATE) && !testing) begin
					nxt_s.send = 1'b1;
					nxt_s.kind = 1'b0;
				end
			end
			default: begin
				nxt_s.ref_st = REF_IDLE;
			end
		endcase
		if (cmd[`WTC_C_CHOOSE] && page_meas && s_ff.ref_fin && s_ff.ref_mode != single_sample_mode) begin
			nxt_s.choose = 1'b1;
			nxt_s.ref_st = REF_IDLE;
			nxt_s.ref_fin = 1'b0;
		end
		if (cmd[`WTC_C_REF] && s_ff.tsrc == SRC_BUS && !testing && page_meas) begin
			nxt_s.ref_go = 1'b1;
			nxt_s.ref_st = REF_RUN;
			nxt_s.ref_fin = 1'b0;
		end
		// sampler output has priority; pending fetch goes next free cycle
		if (!nxt_s.send && (wave_ready || meas_done) && |s_ff.pend) begin
			nxt_s.send = 1'b1;
			nxt_s.kind = ~s_ff.pend[0];
			if (s_ff.pend[0]) begin
				nxt_s.pend[0] = cmd[`WTC_C_FREF];
			end else begin
				nxt_s.pend[1] = cmd[`WTC_C_FTST];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			s_ff <= '0;
			s_ff.rate <= `WTC_RATE_RST;
			s_ff.zoom <= ZOOM_MIN;
			s_ff.pts <= `WTC_PTS_MIN;
			s_ff.ref_mode <= sequence_cycle_mode;
			s_ff.tsrc <= manual_trigger;
			s_ff.stat_ch <= `WTC_CH_OFF;
			s_ff.ref_st <= REF_IDLE;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign prdata = s_ff.rdata;
	assign pready = s_ff.rdy;
	assign pslverr = s_ff.err;
	assign rate_sel = s_ff.rate;
	assign zoom_sel = s_ff.zoom;
	assign zoom_pts = s_ff.pts;
	assign meas_start = s_ff.meas_go;
	assign ref_start = s_ff.ref_go;
	assign ref_choose = s_ff.choose;
	assign stat_save = s_ff.save;
	assign wave_send = s_ff.send;
	assign wave_kind = s_ff.kind;

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	property p_rate_hold;
		wr && hit(paddr, `WTC_A_RATE) && testing |=> $stable(rate_sel);
	endproperty
	a_rate_hold: assert property (p_rate_hold) else $error("rate changed in test");

	property p_rate_take;
		wr && hit(paddr, `WTC_A_RATE) && !testing |=> rate_sel == $past(pwdata[2:0]);
	endproperty
	a_rate_take: assert property (p_rate_take) else $error("rate not taken");

	property p_zoom_hold;
		wr && hit(paddr, `WTC_A_ZOOM) && testing |=> $stable(zoom_sel);
	endproperty
	a_zoom_hold: assert property (p_zoom_hold) else $error("zoom changed in test");

	property p_zoom_pts;
		zoom_sel == ZOOM_MED |-> zoom_pts == `WTC_PTS_MED;
	endproperty
	a_zoom_pts: assert property (p_zoom_pts) else $error("zoom points wrong");

	property p_ref_go;
		ref_start |-> $past(s_ff.tsrc == SRC_BUS && !testing && page_meas);
	endproperty
	a_ref_go: assert property (p_ref_go) else $error("bad reference trigger");

	property p_meas_go;
		meas_start |-> $past(page_meas);
	endproperty
	a_meas_go: assert property (p_meas_go) else $error("trigger off page");

	property p_seq_send;
		s_ff.ref_st == REF_RUN && ref_pass_done |=> wave_send && !wave_kind;
	endproperty
	a_seq_send: assert property (p_seq_send) else $error("reference not sent");

	property p_fetch;
		s_ff.pend[1] && !s_ff.pend[0] && meas_done && !(s_ff.ref_st == REF_RUN && ref_pass_done)
			&& !(s_ff.ref_st == REF_DONE && wr && hit(paddr, `WTC_A_RATE) && !testing)
			|=> wave_send && wave_kind;
	endproperty
	a_fetch: assert property (p_fetch) else $error("held fetch not answered");

	property p_clr;
		cmd[`WTC_C_CLR] |=> s_ff.cnt == '0;
	endproperty
	a_clr: assert property (p_clr) else $error("counters not cleared");

	property p_stat_ch;
		s_ff.stat_ch == `WTC_CH_ON || s_ff.stat_ch == `WTC_CH_OFF;
	endproperty
	a_stat_ch: assert property (p_stat_ch) else $error("bad statistics code");

	property p_cres_off;
		psel && penable && !pready && hit(paddr, `WTC_A_CRES) && !meas.func_on
			|=> prdata == `WTC_CRES_OFF;
	endproperty
	a_cres_off: assert property (p_cres_off) else $error("result code not 2");

	property p_freq;
		psel && penable && !pready && hit(paddr, `WTC_A_FREQ) && cursor.cur_same |=> prdata == `WTC_NA_F;
	endproperty
	a_freq: assert property (p_freq) else $error("frequency sentinel missing");

	property p_choose;
		ref_choose |-> $past(page_meas && s_ff.ref_fin);
	endproperty
	a_choose: assert property (p_choose) else $error("selection not allowed");

	property p_apb;
		psel && penable |-> ##[0:1] pready;
	endproperty
	a_apb: assert property (p_apb) else $error("no ready");

	property p_mode_keep;
		wr && hit(paddr, `WTC_A_REFMODE) && pwdata[1:0] == REFMODE_BAD |=> $stable(s_ff.ref_mode);
	endproperty
	a_mode_keep: assert property (p_mode_keep) else $error("bad mode code taken");

	property p_zoom_take;
		wr && hit(paddr, `WTC_A_ZOOM) && !testing && pwdata[1:0] != ZOOM_BAD |=> zoom_sel == $past(pwdata[1:0]);
	endproperty
	a_zoom_take: assert property (p_zoom_take) else $error("zoom not taken");

	property p_zoom_min;
		zoom_sel == ZOOM_MIN |-> zoom_pts == `WTC_PTS_MIN;
	endproperty
	a_zoom_min: assert property (p_zoom_min) else $error("full zoom points wrong");

	property p_tsrc_take;
		wr && hit(paddr, `WTC_A_TSRC) |=> s_ff.tsrc == $past(pwdata[1:0]);
	endproperty
	a_tsrc_take: assert property (p_tsrc_take) else $error("source not taken");

	property p_stat_take;
		wr && hit(paddr, `WTC_A_STATEN) && (pwdata[7:0] == `WTC_CH_ON || pwdata[7:0] == `WTC_CH_OFF)
			|=> s_ff.stat_ch == $past(pwdata[7:0]);
	endproperty
	a_stat_take: assert property (p_stat_take) else $error("statistics code not taken");

	property p_save;
		cmd[`WTC_C_SAVE] |=> stat_save;
	endproperty
	a_save: assert property (p_save) else $error("save pulse missing");

	property p_meas_take;
		cmd[`WTC_C_TRIG] && page_meas |=> meas_start;
	endproperty
	a_meas_take: assert property (p_meas_take) else $error("trigger lost");

	property p_ref_take;
		cmd[`WTC_C_REF] && s_ff.tsrc == SRC_BUS && !testing && page_meas |=> ref_start;
	endproperty
	a_ref_take: assert property (p_ref_take) else $error("reference trigger lost");

	property p_resend;
		s_ff.ref_st == REF_DONE && wr && hit(paddr, `WTC_A_RATE) && !testing |=> wave_send && !wave_kind;
	endproperty
	a_resend: assert property (p_resend) else $error("no resend on rate change");

	property p_one_cycle;
		s_ff.ref_st == REF_RUN && ref_pass_done && s_ff.ref_mode == single_cycle_mode
			&& !cmd[`WTC_C_REF] && !cmd[`WTC_C_CHOOSE] |=> s_ff.ref_st == REF_DONE;
	endproperty
	a_one_cycle: assert property (p_one_cycle) else $error("one-cycle run not held");

	property p_cres_nodata;
		psel && penable && !pready && hit(paddr, `WTC_A_CRES) && meas.func_on && !wave_ready
			|=> prdata == `WTC_CRES_NODATA;
	endproperty
	a_cres_nodata: assert property (p_cres_nodata) else $error("result code not 3");

	property p_na_coro;
		psel && penable && !pready && hit(paddr, `WTC_A_CORO) && !meas.cmp_en[2] |=> prdata == `WTC_NA_CORO;
	endproperty
	a_na_coro: assert property (p_na_coro) else $error("corona sentinel missing");

	property p_stat_off;
		s_ff.stat_ch == `WTC_CH_OFF && !cmd[`WTC_C_CLR] |=> $stable(s_ff.cnt);
	endproperty
	a_stat_off: assert property (p_stat_off) else $error("counted while off");

	c_ref: cover property (ref_start ##[1:20] wave_send);
	c_fetch: cover property (s_ff.pend[1] ##[1:20] wave_send && wave_kind);
	c_resend: cover property (s_ff.ref_st == REF_DONE && wave_send);
endmodule

// ---- tb/tb.sv ----
`timescale 1ns/1ns
`include "wtc_consts.svh"
module tb
	import wtc_pkg::*;
;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic busy = 1'b0;
	logic page = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic [31:0] rdv;
	logic pready, pslverr, errv, testing, page_meas, wave_ready, meas_done, ref_pass_done;
	wtc_meas_t meas = '0;
	wtc_cursor_t cursor = '0;
	logic [2:0] rate_sel;
	logic [1:0] zoom_sel;
	logic [9:0] zoom_pts;
	logic meas_start, ref_start, ref_choose, stat_save, wave_send, wave_kind, last_kind;
	int err_total = 0;
	int samples_checked = 0;
	int n_ms = 0;
	int n_rs = 0;
	int n_ch = 0;
	int n_sv = 0;
	int n_ws = 0;
	int i;
	always #5 clk = ~clk;
	wtc_top i_wtc_top (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.testing(testing), .page_meas(page_meas), .wave_ready(wave_ready), .meas_done(meas_done),
		.ref_pass_done(ref_pass_done), .meas(meas), .cursor(cursor), .rate_sel(rate_sel),
		.zoom_sel(zoom_sel), .zoom_pts(zoom_pts), .meas_start(meas_start), .ref_start(ref_start),
		.ref_choose(ref_choose), .stat_save(stat_save), .wave_send(wave_send), .wave_kind(wave_kind));
	wtc_far i_wtc_far (.clk(clk), .rstn(rstn), .meas_start(meas_start), .ref_start(ref_start),
		.busy_req(busy), .page_req(page), .testing(testing), .page_meas(page_meas),
		.wave_ready(wave_ready), .meas_done(meas_done), .ref_pass_done(ref_pass_done));
	// pulses are one cycle, so counting per edge sees each once
	always @(posedge clk) begin
		if (meas_start === 1'b1) n_ms++;
		if (ref_start === 1'b1) n_rs++;
		if (ref_choose === 1'b1) n_ch++;
		if (stat_save === 1'b1) n_sv++;
		if (wave_send === 1'b1) begin
			n_ws++;
			last_kind = wave_kind;
		end
	end
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		rdv = prdata;
		errv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 20) chk("pready", 32'h1, 32'h0);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk($sformatf("reg %h", a), e, rdv);
	endtask
	task cmd(input int b);
		wr(`WTC_A_CMD, 32'h1 << b);
		repeat (12) @(posedge clk);
	endtask
	task test_done;
		$display("checked %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	initial begin
		#300000;
		err_total++;
		test_done;
	end
	initial begin
		meas.func_on = 1'b1;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		rd(`WTC_A_RATE, 32'h100);
		rd(`WTC_A_ZOOM, 32'h03c00000);
		rd(`WTC_A_REFMODE, 32'h0);
		rd(`WTC_A_TSRC, 32'h0);
		rd(`WTC_A_STATEN, 32'h30);
		rd(`WTC_A_CRES, `WTC_CRES_NODATA);
		rd(`WTC_A_STATUS, 32'h0);
		$display("test reset done");
		for (i = 0; i < 8; i++) begin
			wr(`WTC_A_RATE, i);
			rd(`WTC_A_RATE, ((32'h1 << i) << 8) | i);
			chk("rate_sel", {29'h0, rate_sel}, i);
		end
		for (i = 0; i < 3; i++) begin
			wr(`WTC_A_ZOOM, i);
			rd(`WTC_A_ZOOM, {6'h0, 10'h3c0 >> i, 14'h0, i[1:0]});
			chk("zoom_pts", {22'h0, zoom_pts}, {22'h0, 10'h3c0 >> i});
			chk("zoom_sel", i, {30'h0, zoom_sel});
		end
		busy <= 1'b1;
		wr(`WTC_A_RATE, 32'h5);
		wr(`WTC_A_ZOOM, 32'h1);
		rd(`WTC_A_RATE, 32'h8007);
		rd(`WTC_A_ZOOM, 32'h00f00002);
		busy <= 1'b0;
		$display("test settings done");
		for (i = 0; i < 3; i++) begin
			wr(`WTC_A_REFMODE, i);
			rd(`WTC_A_REFMODE, i);
		end
		wr(`WTC_A_REFMODE, 32'h3);
		rd(`WTC_A_REFMODE, 32'h2);
		for (i = 0; i < 4; i++) begin
			wr(`WTC_A_TSRC, i);
			rd(`WTC_A_TSRC, i);
		end
		wr(`WTC_A_STATEN, 32'h31);
		wr(`WTC_A_STATEN, 32'h35);
		rd(`WTC_A_STATEN, 32'h31);
		wr(`WTC_A_REFMODE, 32'h0);
		cmd(`WTC_C_REF);
		chk("ref off page", n_rs, 0);
		page <= 1'b1;
		busy <= 1'b1;
		cmd(`WTC_C_REF);
		chk("ref testing", n_rs, 0);
		busy <= 1'b0;
		wr(`WTC_A_TSRC, 32'h0);
		cmd(`WTC_C_REF);
		chk("ref manual", n_rs, 0);
		wr(`WTC_A_TSRC, 32'h3);
		cmd(`WTC_C_REF);
		chk("ref start", n_rs, 1);
		chk("ref send", n_ws, 1);
		chk("ref kind", {31'h0, last_kind}, 0);
		wr(`WTC_A_REFMODE, 32'h1);
		cmd(`WTC_C_REF);
		chk("one cycle send", n_ws, 2);
		wr(`WTC_A_RATE, 32'h0);
		repeat (4) @(posedge clk);
		chk("rate resend", n_ws, 3);
		page <= 1'b0;
		cmd(`WTC_C_CHOOSE);
		chk("choose off page", n_ch, 0);
		page <= 1'b1;
		cmd(`WTC_C_CHOOSE);
		chk("choose", n_ch, 1);
		wr(`WTC_A_REFMODE, 32'h2);
		cmd(`WTC_C_REF);
		chk("one sample send", 4, n_ws);
		cmd(`WTC_C_CHOOSE);
		chk("choose one sample", 1, n_ch);
		$display("test reference done");
		meas.cmp_en <= 4'hf;
		meas.pass <= 5'h1f;
		cmd(`WTC_C_FTST);
		chk("fetch held", 4, n_ws);
		rd(`WTC_A_STATUS, 32'h42);
		page <= 1'b0;
		cmd(`WTC_C_TRIG);
		chk("trig off page", n_ms, 0);
		page <= 1'b1;
		cmd(`WTC_C_TRIG);
		chk("trig", n_ms, 1);
		chk("fetch send", 5, n_ws);
		chk("fetch kind", {31'h0, last_kind}, 1);
		for (i = 0; i < 10; i++) rd(`WTC_A_STAT + 4 * i, 32'h1);
		cmd(`WTC_C_SAVE);
		chk("save", n_sv, 1);
		cmd(`WTC_C_CLR);
		rd(`WTC_A_STAT, 32'h0);
		rd(`WTC_A_STEND, 32'h0);
		cmd(`WTC_C_FREF);
		chk("ref fetch kind", {31'h0, last_kind}, 0);
		$display("test measure done");
		meas.area <= 32'h1234;
		rd(`WTC_A_CRES, 32'h1);
		rd(`WTC_A_AREA, 32'h1234);
		meas.cmp_en <= 4'h0;
		rd(`WTC_A_AREA, `WTC_NA_F);
		rd(`WTC_A_ZONE, `WTC_NA_F);
		rd(`WTC_A_PHAS, `WTC_NA_F);
		rd(`WTC_A_CORO, `WTC_NA_CORO);
		meas.func_on <= 1'b0;
		rd(`WTC_A_CRES, `WTC_CRES_OFF);
		cursor <= '{freq: 32'h55, cur_same: 1'b1, volt: 32'h66, tim: 32'h77};
		rd(`WTC_A_FREQ, `WTC_NA_F);
		cursor.cur_same <= 1'b0;
		rd(`WTC_A_FREQ, 32'h55);
		rd(`WTC_A_VOLT, 32'h66);
		rd(`WTC_A_TIME, 32'h77);
		apb(1'b0, 8'hfc, 32'h0);
		chk("pslverr", {31'h0, errv}, 1);
		chk("unmapped data", rdv, 0);
		$display("test results done");
		test_done;
	end
endmodule

// ---- tb/wtc_far.sv ----
`timescale 1ns/1ns
module wtc_far (
	// clock and reset
	input logic clk,
	input logic rstn,
	// starts from the block, state from the bench
	input logic meas_start,
	input logic ref_start,
	input logic busy_req,
	input logic page_req,
	// tester status
	output logic testing,
	output logic page_meas,
	output logic wave_ready,
	output logic meas_done,
	output logic ref_pass_done
);
	logic [2:0] mt_ff;
	logic [2:0] rt_ff;
	assign testing = busy_req;
	assign page_meas = page_req;
	// each run ends five cycles after its start pulse; data stays ready after a measurement run
	always_ff @(posedge clk) begin
		if (!rstn) begin
			mt_ff <= 3'h0;
			rt_ff <= 3'h0;
			wave_ready <= 1'b0;
			meas_done <= 1'b0;
			ref_pass_done <= 1'b0;
		end else begin
			mt_ff <= meas_start ? 3'h4 : (mt_ff != 3'h0 ? mt_ff - 3'h1 : 3'h0);
			rt_ff <= ref_start ? 3'h4 : (rt_ff != 3'h0 ? rt_ff - 3'h1 : 3'h0);
			meas_done <= mt_ff == 3'h1;
			ref_pass_done <= rt_ff == 3'h1;
			if (mt_ff == 3'h1) begin
				wave_ready <= 1'b1;
			end
		end
	end
endmodule
